// ---- design/apc_pins.sv ----
// Clock, frame-sync and serial-flag pin logic of a serial audio port.
// Assumes a plain register port on sys_clk_in and a serial link clock
// on link_clk_in that belongs to the frame-sync logic of the port.
`include "apc_defs.svh"
`default_nettype none

// Function
// - An input receiver clock pin can replace the core clock as the receiver clock.
// - An input transmitter clock pin can replace the core clock as the transmitter clock.
// - A clock pin set as output carries a high-frequency clock made by the device.
// - In port mode every pin is separately a port input, port output or disconnected.
// - After reset every clock and frame-sync pin is disconnected, neither driven nor read.
// - Without sync mode the receiver frame-sync pin is the receivers' frame sync.
// - In sync mode that pin is flag 1, or the buffer enable when that option and its direction bit are set.
// - As a flag the receiver frame-sync pin takes its direction from the receiver direction bit.
// - As output flag 1 the pin shows the control bit, updated on frame sync or time slot.
// - As input flag 1 the pin level is captured on frame sync or time slot into a status bit.
// - In sync mode the transmitter frame-sync pin gives frame sync to transmitters and receivers.
// - In async mode the transmitter frame-sync pin serves the transmitters only.
// - The transmitter frame-sync pin direction follows the transmitter direction bit.
module apc_pins #(
   parameter int SLOT_LEN = `APC_SLOT_LEN
) (
   // Core clock and reset.
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // Serial link clock.
   input  wire logic        link_clk_in,
   // Register port.
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   // Pins: index 0 rx clock, 1 tx clock, 2 rx sync, 3 tx sync.
   input  wire logic [3:0]  pin_in,
   output logic      [3:0]  pin_out,
   output logic      [3:0]  pin_oe_out,
   // Frame syncs from the serial engines, link domain.
   input  wire logic        rx_fs_gen_in,
   input  wire logic        tx_fs_gen_in,
   input  wire logic        tx_buf_en_in,
   // Frame syncs and clock selects to the serial engines.
   output logic             rx_frame_sync_out,
   output logic             tx_frame_sync_out,
   output logic             rx_clk_sel_out,
   output logic             tx_clk_sel_out
);

   // --------------------------------------------------------------------
   // Registers.
   // --------------------------------------------------------------------
   logic [3:0]  ctrl;
   logic [15:0] rx_clock_control_reg;
   logic [15:0] tx_clock_control_reg;
   logic [7:0]  pmode;
   logic [3:0]  pdata;
   logic [3:0]  pin_m;
   logic [3:0]  pin_s;
   logic [3:0]  pin_q;
   logic        if1_m;
   logic        if1_s;
   logic [7:0]  rdiv_cnt;
   logic [7:0]  tdiv_cnt;
   logic        rhf_clk;
   logic        thf_clk;

   // Link domain state.
   apc_pkg::apc_cfg_t cfg_now;
   apc_pkg::apc_cfg_t cfg_m;
   apc_pkg::apc_cfg_t cfg_l;
   logic [1:0]  rfs_aud_m;
   logic [1:0]  tfs_aud_m;
   logic        rfs_aud_l;
   logic        tfs_aud_l;
   logic [1:0]  rfs_pin_m;
   logic [1:0]  tfs_pin_m;
   logic        rfs_pin_l;
   logic        tfs_pin_l;
   logic        fs_t;
   logic        fs_t_d;
   logic [7:0]  slot_cnt;
   logic        align;
   logic        of1_pin;
   logic        if1_l;
   logic        rfs_drv;
   logic        tfs_drv;

   // Decodes the mode of one pin from the mode register.
   function automatic apc_pkg::apc_pin_mode_t pin_mode(
      input logic [7:0] modes,
      input int         idx
   );
      pin_mode = apc_pkg::apc_pin_mode_t'(modes[2*idx +: 2]);
   endfunction

   // --------------------------------------------------------------------
   // Register port.
   // --------------------------------------------------------------------

   // Software writes to the control registers.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl  <= 4'h0;
         rx_clock_control_reg  <= 16'h0000;
         tx_clock_control_reg  <= 16'h0000;
         pmode <= 8'h00;
         pdata <= 4'h0;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            `APC_CTRL_OFS:  ctrl  <= reg_wdata_in[3:0];
            `APC_RX_CLOCK_CONTROL_REG_OFS:  rx_clock_control_reg  <= reg_wdata_in[15:0];
            `APC_TX_CLOCK_CONTROL_REG_OFS:  tx_clock_control_reg  <= reg_wdata_in[15:0];
            `APC_PMODE_OFS: pmode <= reg_wdata_in[7:0];
            `APC_PDATA_OFS: pdata <= reg_wdata_in[3:0];
            default:        ;
         endcase
      end
   end

   // Read data stands in the cycle after the read strobe only.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= `APC_RST_WORD;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            `APC_CTRL_OFS:  reg_rdata_out <= {28'h0000000, ctrl};
            `APC_STAT_OFS:  reg_rdata_out <= {31'h00000000, if1_s};
            `APC_RX_CLOCK_CONTROL_REG_OFS:  reg_rdata_out <= {16'h0000, rx_clock_control_reg};
            `APC_TX_CLOCK_CONTROL_REG_OFS:  reg_rdata_out <= {16'h0000, tx_clock_control_reg};
            `APC_PMODE_OFS: reg_rdata_out <= {24'h000000, pmode};
            `APC_PDATA_OFS: reg_rdata_out <= {28'h0000000, pin_q};
            default:        reg_rdata_out <= `APC_RST_WORD;
         endcase
      end else begin
         reg_rdata_out <= `APC_RST_WORD;
      end
   end

   // --------------------------------------------------------------------
   // Port input sampling and input flag crossing.
   // --------------------------------------------------------------------

   // Pins pass two plain flops, then are kept only where set as input.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_m <= 4'h0;
         pin_s <= 4'h0;
         pin_q <= 4'h0;
      end else begin
         pin_m <= pin_in;
         pin_s <= pin_m;
         for (int i = 0; i < 4; i++) begin
            pin_q[i] <= (pin_mode(pmode, i) == apc_pkg::PM_IN)
                        ? pin_s[i] : 1'b0;
         end
      end
   end

   // The captured input flag reaches the status register.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         if1_m <= 1'b0;
         if1_s <= 1'b0;
      end else begin
         if1_m <= if1_l;
         if1_s <= if1_m;
      end
   end

   // --------------------------------------------------------------------
   // High-frequency clock pins.
   // --------------------------------------------------------------------

   // Receiver clock output divided from the core clock.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdiv_cnt <= 8'h00;
         rhf_clk  <= 1'b0;
      end else if (rdiv_cnt >= rx_clock_control_reg[`APC_CCR_DIV_HI:`APC_CCR_DIV_LO]) begin
         rdiv_cnt <= 8'h00;
         rhf_clk  <= ~rhf_clk;
      end else begin
         rdiv_cnt <= rdiv_cnt + 8'h01;
      end
   end

   // Transmitter clock output divided from the core clock.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tdiv_cnt <= 8'h00;
         thf_clk  <= 1'b0;
      end else if (tdiv_cnt >= tx_clock_control_reg[`APC_CCR_DIV_HI:`APC_CCR_DIV_LO]) begin
         tdiv_cnt <= 8'h00;
         thf_clk  <= ~thf_clk;
      end else begin
         tdiv_cnt <= tdiv_cnt + 8'h01;
      end
   end

   // Engines take the pin clock when it is an input and selected.
   assign rx_clk_sel_out = (pin_mode(pmode, `APC_PIN_RHF)
                            == apc_pkg::PM_AUDIO)
                           & ~rx_clock_control_reg[`APC_CCR_HFO]
                           & rx_clock_control_reg[`APC_CCR_HFSRC];
   assign tx_clk_sel_out = (pin_mode(pmode, `APC_PIN_THF)
                            == apc_pkg::PM_AUDIO)
                           & ~tx_clock_control_reg[`APC_CCR_HFO]
                           & tx_clock_control_reg[`APC_CCR_HFSRC];

   // --------------------------------------------------------------------
   // Configuration crossing into the link domain.
   // --------------------------------------------------------------------

   // Gathers the quasi-static settings that the link logic reads.
   always_comb begin
      cfg_now.sync_mode_select        = ctrl[`APC_CTRL_SYNC];
      cfg_now.tx_ext_buffer_enable    = ctrl[`APC_CTRL_TX_EXT_BUFFER_ENABLE];
      cfg_now.rx_frame_sync_direction = rx_clock_control_reg[`APC_CCR_FSD];
      cfg_now.tx_frame_sync_direction = tx_clock_control_reg[`APC_CCR_FSD];
      cfg_now.network_mode            = ctrl[`APC_CTRL_NET];
      cfg_now.output_flag_1           = ctrl[`APC_CTRL_OF1];
   end

   // Two flops carry each setting, and three flops each audio enable, into the link domain.
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_m     <= '0;
         cfg_l     <= '0;
         rfs_aud_m <= 2'h0;
         tfs_aud_m <= 2'h0;
         rfs_aud_l <= 1'b0;
         tfs_aud_l <= 1'b0;
      end else begin
         cfg_m     <= cfg_now;
         cfg_l     <= cfg_m;
         rfs_aud_m <= {rfs_aud_m[0],
                       pin_mode(pmode, `APC_PIN_RFS) == apc_pkg::PM_AUDIO};
         tfs_aud_m <= {tfs_aud_m[0],
                       pin_mode(pmode, `APC_PIN_TFS) == apc_pkg::PM_AUDIO};
         rfs_aud_l <= rfs_aud_m[1];
         tfs_aud_l <= tfs_aud_m[1];
      end
   end

   // --------------------------------------------------------------------
   // Frame syncs in the link domain.
   // --------------------------------------------------------------------

   // Frame-sync pins pass two link flops before the audio gate reads them.
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rfs_pin_m <= 2'h0;
         tfs_pin_m <= 2'h0;
         rfs_pin_l <= 1'b0;
         tfs_pin_l <= 1'b0;
      end else begin
         rfs_pin_m <= {rfs_pin_m[0], pin_in[`APC_PIN_RFS]};
         tfs_pin_m <= {tfs_pin_m[0], pin_in[`APC_PIN_TFS]};
         rfs_pin_l <= rfs_aud_l & rfs_pin_m[1];
         tfs_pin_l <= tfs_aud_l & tfs_pin_m[1];
      end
   end

   // Transmitter frame sync from the engine or from the pin.
   always_comb begin
      fs_t = cfg_l.tx_frame_sync_direction ? tx_fs_gen_in
                                           : tfs_pin_l;
   end

   // Frame syncs handed to the engines.
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_frame_sync_out <= 1'b0;
         rx_frame_sync_out <= 1'b0;
      end else begin
         tx_frame_sync_out <= tfs_aud_l & fs_t;
         if (cfg_l.sync_mode_select) begin
            rx_frame_sync_out <= tfs_aud_l & fs_t;
         end else begin
            rx_frame_sync_out <= cfg_l.rx_frame_sync_direction
                                 ? rx_fs_gen_in : rfs_pin_l;
         end
      end
   end

   // Slot counter restarts on each frame sync rising edge.
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fs_t_d   <= 1'b0;
         slot_cnt <= 8'h00;
      end else begin
         fs_t_d <= fs_t;
         if ((fs_t & ~fs_t_d) || (slot_cnt == 8'(SLOT_LEN - 1))) begin
            slot_cnt <= 8'h00;
         end else begin
            slot_cnt <= slot_cnt + 8'h01;
         end
      end
   end

   // Flag updates follow frame sync, or each slot in network mode.
   assign align = (fs_t & ~fs_t_d)
                  | (cfg_l.network_mode
                     & (slot_cnt == 8'(SLOT_LEN - 1)));

   // Flag 1 output update and input capture on the alignment event.
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         of1_pin <= 1'b0;
         if1_l   <= 1'b0;
      end else if (align) begin
         of1_pin <= cfg_l.output_flag_1;
         if (cfg_l.sync_mode_select & ~cfg_l.rx_frame_sync_direction) begin
            if1_l <= rfs_pin_l;
         end
      end
   end

   // Drive values of the frame-sync pins in audio mode.
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rfs_drv <= 1'b0;
         tfs_drv <= 1'b0;
      end else begin
         tfs_drv <= tx_fs_gen_in;
         if (!cfg_l.sync_mode_select) begin
            rfs_drv <= rx_fs_gen_in;
         end else if (cfg_l.tx_ext_buffer_enable) begin
            rfs_drv <= tx_buf_en_in;
         end else begin
            rfs_drv <= of1_pin;
         end
      end
   end

   // --------------------------------------------------------------------
   // Pin drivers.
   // --------------------------------------------------------------------

   // Audio drive and enable of each pin, one net bit per pin.
   wire logic [3:0] aud_oe;
   wire logic [3:0] aud_val;

   // Each pin takes the audio drive that belongs to its role.
   for (genvar g = 0; g < 4; g++) begin : g_pin
      if (g == `APC_PIN_RHF) begin : g_rhf
         assign aud_oe[g]  = rx_clock_control_reg[`APC_CCR_HFO];
         assign aud_val[g] = rhf_clk;
      end else if (g == `APC_PIN_THF) begin : g_thf
         assign aud_oe[g]  = tx_clock_control_reg[`APC_CCR_HFO];
         assign aud_val[g] = thf_clk;
      end else if (g == `APC_PIN_RFS) begin : g_rfs
         assign aud_oe[g]  = rx_clock_control_reg[`APC_CCR_FSD];
         assign aud_val[g] = rfs_drv;
      end else begin : g_tfs
         assign aud_oe[g]  = tx_clock_control_reg[`APC_CCR_FSD];
         assign aud_val[g] = tfs_drv;
      end
   end

   // Each pin follows its own mode: port, audio or disconnected.
   always_comb begin
      pin_oe_out = 4'h0;
      pin_out    = 4'h0;
      for (int i = 0; i < 4; i++) begin
         unique case (pin_mode(pmode, i))
            apc_pkg::PM_OUT: begin
               pin_oe_out[i] = 1'b1;
               pin_out[i]    = pdata[i];
            end
            apc_pkg::PM_AUDIO: begin
               pin_oe_out[i] = aud_oe[i];
               pin_out[i]    = aud_oe[i] & aud_val[i];
            end
            apc_pkg::PM_DISC, apc_pkg::PM_IN: begin
               pin_oe_out[i] = 1'b0;
               pin_out[i]    = 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- design/apc_defs.svh ----
// Register offsets, field positions, reset values and timing counts of
// the audio port clock and sync pin block.
// Assumes inclusion by bare name from the design file.
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

// -----------------------------------------------------------------------
// Register offsets.
// -----------------------------------------------------------------------
`define APC_CTRL_OFS    8'h00
`define APC_STAT_OFS    8'h04
`define APC_RX_CLOCK_CONTROL_REG_OFS    8'h08
`define APC_TX_CLOCK_CONTROL_REG_OFS    8'h0C
`define APC_PMODE_OFS   8'h10
`define APC_PDATA_OFS   8'h14

// -----------------------------------------------------------------------
// Field positions.
// -----------------------------------------------------------------------
`define APC_CTRL_SYNC   0
`define APC_CTRL_TX_EXT_BUFFER_ENABLE   1
`define APC_CTRL_OF1    2
`define APC_CTRL_NET    3
`define APC_STAT_IF1    0
`define APC_CCR_FSD     0
`define APC_CCR_HFO     1
`define APC_CCR_HFSRC   2
`define APC_CCR_DIV_LO  8
`define APC_CCR_DIV_HI  15

// -----------------------------------------------------------------------
// Pin indices and reset values.
// -----------------------------------------------------------------------
`define APC_PIN_RHF     0
`define APC_PIN_THF     1
`define APC_PIN_RFS     2
`define APC_PIN_TFS     3
`define APC_RST_WORD    32'h0000_0000
`define APC_SLOT_LEN    32

`endif

// ---- design/apc_pkg.sv ----
// Types shared by the audio port clock and sync pin block.
// Assumes nothing beyond the constants header.
`default_nettype none

package apc_pkg;

   // Per-pin mode: disconnected, port input, port output, audio function.
   typedef enum logic [1:0] {
      PM_DISC,
      PM_IN,
      PM_OUT,
      PM_AUDIO
   } apc_pin_mode_t;

   // Configuration that crosses into the link clock domain.
   typedef struct packed {
      logic sync_mode_select;
      logic tx_ext_buffer_enable;
      logic rx_frame_sync_direction;
      logic tx_frame_sync_direction;
      logic network_mode;
      logic output_flag_1;
   } apc_cfg_t;

endpackage

`default_nettype wire

// ---- test/apc_codec_model.sv ----
// Model of the converter side of the audio port pins.
// Assumes the link clock runs free; pins the device leaves undriven show this model's levels.
`default_nettype none

module apc_codec_model (
   // Link clock and scenario controls.
   input  wire logic       link_clk_in,
   input  wire logic       fs_on_in,
   input  wire logic       flag_in,
   // Device side of the pins.
   input  wire logic [3:0] pin_out_in,
   input  wire logic [3:0] pin_oe_in,
   // Resolved pin levels and engine frame sync.
   output logic      [3:0] pin_level_out,
   output logic            fs_gen_out
);
   logic [3:0] cnt = 4'h0;
   logic       hf  = 1'h0;
   logic [3:0] ext;

   // Frame counter and a steady clock for both clock pins.
   always_ff @(posedge link_clk_in) begin
      cnt <= cnt + 4'h1;
      hf  <= ~hf;
   end

   // One-cycle frame sync every sixteen link clocks, else pulled low.
   assign fs_gen_out = fs_on_in && (cnt == 4'hF);
   assign ext = {fs_gen_out, flag_in, hf, hf};
   // A pin the device drives shows the device, others show this model.
   assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext);
endmodule

`default_nettype wire

// ---- test/apc_pins_props.sv ----
// Checker of the audio port clock and sync pin block.
// Assumes binding to apc_pins; it shadows registers from the write port.
`default_nettype none

module apc_pins_props #(
   parameter int SLOT_LEN = 32
) (
   // Clocks and reset.
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   input wire logic        link_clk_in,
   // Register writes.
   input wire logic [7:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_wr_in,
   // Pins and frame syncs.
   input wire logic [3:0]  pin_in,
   input wire logic [3:0]  pin_out,
   input wire logic [3:0]  pin_oe_out,
   input wire logic        tx_fs_gen_in,
   input wire logic        rx_frame_sync_out,
   input wire logic        tx_frame_sync_out
);
   // ---------------------------------------------------------------
   // Register shadows.
   // ---------------------------------------------------------------
   logic [7:0] pmode;
   logic [3:0] pdata, ctrl, aud, outm, inm;
   logic [2:0] rx_clock_control_reg, tx_clock_control_reg;
   logic [4:0] quiet;

   // Copies of the writable registers.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         {pmode, pdata, ctrl, rx_clock_control_reg, tx_clock_control_reg} <= 22'h0;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            8'h00: ctrl  <= reg_wdata_in[3:0];
            8'h08: rx_clock_control_reg  <= reg_wdata_in[2:0];
            8'h0C: tx_clock_control_reg  <= reg_wdata_in[2:0];
            8'h10: pmode <= reg_wdata_in[7:0];
            8'h14: pdata <= reg_wdata_in[3:0];
            default: ;
         endcase
      end
   end

   // Cycles since the last write, so the link checks see settled setup.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         quiet <= 5'h00;
      end else if (reg_wr_in) begin
         quiet <= 5'h00;
      end else if (quiet != 5'h1F) begin
         quiet <= quiet + 5'h01;
      end
   end

   // Per-pin mode masks.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         aud[i]  = pmode[2*i+:2] == 2'h3;
         outm[i] = pmode[2*i+:2] == 2'h2;
         inm[i]  = !pmode[2*i+1];
      end
   end

   property p_rst_idle;
      @(posedge sys_clk_in) disable iff (rst_in)
         $fell(rst_in) |-> pin_oe_out == 4'h0 && pin_out == 4'h0;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("pins active after reset");
   property p_oe_cause;
      @(posedge sys_clk_in) disable iff (rst_in)
         $changed(pin_oe_out) |-> $past(reg_wr_in);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("pin enable moved without a write");
   property p_port;
      @(posedge sys_clk_in) disable iff (rst_in)
         (pin_oe_out & (inm | outm)) == outm
         && (pin_out & outm) == (pdata & outm);
   endproperty
   a_port: assert property (p_port)
      else $error("port pin drive wrong");
   property p_hf_dir;
      @(posedge sys_clk_in) disable iff (rst_in)
         (!aud[0] || pin_oe_out[0] == rx_clock_control_reg[1])
         && (!aud[1] || pin_oe_out[1] == tx_clock_control_reg[1]);
   endproperty
   a_hf_dir: assert property (p_hf_dir)
      else $error("clock pin direction wrong");
   property p_rfs_dir;
      @(posedge sys_clk_in) disable iff (rst_in)
         aud[2] |-> pin_oe_out[2] == rx_clock_control_reg[0];
   endproperty
   a_rfs_dir: assert property (p_rfs_dir)
      else $error("rx sync pin direction wrong");
   property p_tfs_dir;
      @(posedge sys_clk_in) disable iff (rst_in)
         aud[3] |-> pin_oe_out[3] == tx_clock_control_reg[0];
   endproperty
   a_tfs_dir: assert property (p_tfs_dir)
      else $error("tx sync pin direction wrong");
   property p_tfs_src;
      @(posedge link_clk_in) disable iff (rst_in)
         quiet == 5'h1F && aud[3] |-> tx_frame_sync_out ==
         (tx_clock_control_reg[0] ? $past(tx_fs_gen_in, 1) : $past(pin_in[3], 4));
   endproperty
   a_tfs_src: assert property (p_tfs_src)
      else $error("tx frame sync source wrong");
   property p_rx_sync;
      @(posedge link_clk_in) disable iff (rst_in)
         quiet == 5'h1F && ctrl[0] |-> rx_frame_sync_out == tx_frame_sync_out;
   endproperty
   a_rx_sync: assert property (p_rx_sync)
      else $error("receivers not on tx frame sync");
endmodule

bind apc_pins apc_pins_props #(.SLOT_LEN(SLOT_LEN)) apc_pins_props_inst (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe_out(pin_oe_out), .tx_fs_gen_in(tx_fs_gen_in),
   .rx_frame_sync_out(rx_frame_sync_out),
   .tx_frame_sync_out(tx_frame_sync_out));

`default_nettype wire

// ---- test/apc_pins_test.sv ----
// Self-checking bench of the audio port clock and sync pin block.
// Assumes the codec model on the pins and the bound checker beside it.
`default_nettype none

module apc_pins_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk_in = 1'h0;
   logic        link_clk   = 1'h0;
   logic        rst_in     = 1'h1;
   logic [7:0]  addr       = 8'h00;
   logic [31:0] wdata      = 32'h0;
   logic        wr = 1'h0, rd = 1'h0, fs_on = 1'h0;
   logic        flag = 1'h0, buf_en = 1'h0;
   logic [31:0] rdata;
   logic [3:0]  pin_lvl, pin_o, pin_oe;
   logic        fs_gen, rx_fs, tx_fs, rx_sel, tx_sel;
   int          miscompares = 0, checks = 0, n;

   // Core clock and an unrelated link clock.
   initial forever #10 sys_clk_in = ~sys_clk_in;
   initial begin
      #7;
      forever #32 link_clk = ~link_clk;
   end

   apc_pins #(.SLOT_LEN(4)) apc_pins_inst (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .pin_in(pin_lvl),
      .pin_out(pin_o), .pin_oe_out(pin_oe), .rx_fs_gen_in(fs_gen),
      .tx_fs_gen_in(fs_gen), .tx_buf_en_in(buf_en),
      .rx_frame_sync_out(rx_fs), .tx_frame_sync_out(tx_fs),
      .rx_clk_sel_out(rx_sel), .tx_clk_sel_out(tx_sel));

   apc_codec_model apc_codec_model_inst (
      .link_clk_in(link_clk), .fs_on_in(fs_on), .flag_in(flag),
      .pin_out_in(pin_o), .pin_oe_in(pin_oe), .pin_level_out(pin_lvl),
      .fs_gen_out(fs_gen));

   // ---------------------------------------------------------------
   // Access and comparison tasks.
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge sys_clk_in);
      wr    <= 1'h0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk_in);
      addr <= a;
      rd   <= 1'h1;
      @(posedge sys_clk_in);
      rd   <= 1'h0;
      @(negedge sys_clk_in);
      check(rdata, e);
   endtask

   // Waits for a fresh transmitter frame sync; a missing one ends the run.
   task automatic wait_fs();
      logic low;
      low = 1'h0;
      for (n = 0; n < 300; n++) begin
         @(negedge sys_clk_in);
         if (low && tx_fs === 1'h1) break;
         if (tx_fs === 1'h0) low = 1'h1;
      end
      if (n == 300) begin
         miscompares++;
         complete_run();
      end
   endtask

   // Counts core cycles until the receiver clock pin changes.
   task automatic hf_gap();
      logic v;
      v = pin_o[0];
      for (n = 1; n < 64; n++) begin
         @(negedge sys_clk_in);
         if (pin_o[0] !== v) break;
      end
   endtask

   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask

   initial begin
      repeat (10) @(posedge sys_clk_in);
      rst_in <= 1'h0;
      // Every register reads zero, nothing driven, status is read-only.
      for (int a = 0; a <= 24; a += 4) rd_reg(8'(a), 32'h0);
      check(pin_oe, 4'h0);
      wr_reg(8'h04, 32'hFFFF_FFFF);
      rd_reg(8'h04, 32'h0);
      end_test("reset");
      // Pin 0 off, 1 out, 2 in, 3 out.
      flag <= 1'h1;
      wr_reg(8'h10, 32'h98);
      wr_reg(8'h14, 32'h2);
      @(negedge sys_clk_in);
      check({pin_oe, pin_o & pin_oe}, 8'hA2);
      rd_reg(8'h14, 32'h4);
      flag <= 1'h0;
      end_test("port");
      // Receiver clock pin out with divider 3, transmitter pin as source.
      wr_reg(8'h10, 32'h0F);
      wr_reg(8'h08, 32'h0302);
      wr_reg(8'h0C, 32'h4);
      rd_reg(8'h08, 32'h0302);
      hf_gap();
      hf_gap();
      check(32'(n), 32'h4);
      check({pin_oe[1:0], rx_sel, tx_sel}, 4'h5);
      wr_reg(8'h08, 32'h4);
      @(negedge sys_clk_in);
      check({pin_oe[0], rx_sel}, 2'h1);
      end_test("clock");
      // Asynchronous transmitter sync from the pin, then driven out.
      wr_reg(8'h10, 32'hFF);
      wr_reg(8'h0C, 32'h0);
      fs_on <= 1'h1;
      wait_fs();
      check({pin_oe[3], rx_fs}, 2'h0);
      wr_reg(8'h0C, 32'h1);
      wr_reg(8'h08, 32'h5);
      wait_fs();
      check({pin_oe[3:2], pin_o[3:2], rx_fs}, 5'h1F);
      end_test("tx sync");
      // Input flag is captured only at a frame sync.
      fs_on <= 1'h0;
      wr_reg(8'h0C, 32'h0);
      wr_reg(8'h08, 32'h0);
      wr_reg(8'h00, 32'h1);
      flag <= 1'h1;
      repeat (40) @(negedge sys_clk_in);
      rd_reg(8'h04, 32'h0);
      fs_on <= 1'h1;
      wait_fs();
      check(rx_fs, 1'h1);
      repeat (10) @(negedge sys_clk_in);
      rd_reg(8'h04, 32'h1);
      end_test("input flag");
      // Output flag waits for a frame sync, or a slot end in network mode, before it shows.
      fs_on <= 1'h0;
      wr_reg(8'h08, 32'h1);
      wr_reg(8'h00, 32'h5);
      repeat (40) @(negedge sys_clk_in);
      check({pin_oe[2], pin_o[2]}, 2'h2);
      fs_on <= 1'h1;
      wait_fs();
      repeat (10) @(negedge sys_clk_in);
      check(pin_o[2], 1'h1);
      fs_on <= 1'h0;
      wr_reg(8'h00, 32'h9);
      repeat (40) @(negedge sys_clk_in);
      check(pin_o[2], 1'h0);
      end_test("output flag");
      // Buffer enable on the receiver sync pin follows the transmitter.
      wr_reg(8'h00, 32'h3);
      for (int v = 1; v >= 0; v--) begin
         @(posedge sys_clk_in);
         buf_en <= 1'(v);
         repeat (20) @(negedge sys_clk_in);
         check({pin_oe[2], pin_o[2]}, {1'h1, 1'(v)});
      end
      end_test("buffer enable");
      // A second reset in mid-run disconnects everything again.
      @(posedge sys_clk_in);
      rst_in <= 1'h1;
      repeat (10) @(posedge sys_clk_in);
      rst_in <= 1'h0;
      @(negedge sys_clk_in);
      check(pin_oe, 4'h0);
      rd_reg(8'h10, 32'h0);
      end_test("second reset");
      complete_run();
   end
endmodule

`default_nettype wire
